// [psrr_consts.svh]
`ifndef PSRR_CONSTS_SVH
`define PSRR_CONSTS_SVH

// Register byte offsets on the bus
`define PSRR_HS_RST_OFFSET 8'h0c
`define PSRR_LS_RST_OFFSET 8'h18

// Reset values
`define PSRR_HS_RST_RESET 32'h0000_0000
`define PSRR_LS_RST_RESET 32'h0000_0000

// Implemented bits; all others are reserved
`define PSRR_HS_RST_MASK 32'h0406_0001
`define PSRR_LS_RST_MASK 32'h7681_2323

// High-speed register bit positions
`define PSRR_HS_DIVIDER_BIT 26
`define PSRR_HS_PORT_SECOND_BIT 18
`define PSRR_HS_PORT_FIRST_BIT 17
`define PSRR_HS_DMA_BIT 0

// Low-speed register bit positions
`define PSRR_LS_SYSTEM_CONFIG_RESET_BIT 30
`define PSRR_LS_DEBUG_BIT 29
`define PSRR_LS_POWER_BIT 28
`define PSRR_LS_OPAMP_SECOND_BIT 26
`define PSRR_LS_OPAMP_FIRST_BIT 25
`define PSRR_LS_COMPARATOR_BIT 23
`define PSRR_LS_SERIAL_BIT 16
`define PSRR_LS_ANALOG_BIT 13
`define PSRR_LS_TIMER_FOURTEEN_BIT 9
`define PSRR_LS_TIMER_THIRTEEN_BIT 8
`define PSRR_LS_TIMER_SIX_BIT 5
`define PSRR_LS_TIMER_TWO_BIT 1
`define PSRR_LS_TIMER_ONE_BIT 0

// Bus data read back for an unmapped or write access
`define PSRR_READ_IDLE 32'h0000_0000

`endif

// [psrr_pkg.sv]
package psrr_pkg;

    typedef logic [31:0] psrr_word_t;
    typedef logic [3:0] psrr_strb_t;
    typedef logic [7:0] psrr_addr_t;

    typedef enum logic [1:0] {
        PSRR_SEL_NONE,
        PSRR_SEL_HS,
        PSRR_SEL_LS
    } psrr_sel_e;

endpackage : psrr_pkg

// [psrr_word.sv]
`timescale 1ns/1ps

module psrr_word #(
    parameter psrr_pkg::psrr_word_t WRITE_MASK = 32'h0000_0000,
    parameter psrr_pkg::psrr_word_t RESET_VALUE = 32'h0000_0000
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    input wire logic wr_en_in,
    input wire psrr_pkg::psrr_strb_t strb_in,
    input wire psrr_pkg::psrr_word_t wdata_in,
    output psrr_pkg::psrr_word_t q_out
);
    import psrr_pkg::*;

    logic [7:0] lane_q [4];

    // One byte lane per strobe so half-word and byte writes touch only their lanes
    for (genvar b = 0; b < 4; b++) begin : g_lane
        always_ff @(posedge clk_in) begin
            if (!reset_n_in) begin
                lane_q[b] <= RESET_VALUE[b*8 +: 8];
            end else if (ce_in && wr_en_in && strb_in[b]) begin
                // Reserved positions never store a one
                lane_q[b] <= wdata_in[b*8 +: 8] & WRITE_MASK[b*8 +: 8];
            end
        end
        assign q_out[b*8 +: 8] = lane_q[b];
    end

endmodule : psrr_word

// [psrr_regs.sv]
`timescale 1ns/1ps
`include "psrr_consts.svh"


module psrr_regs (
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic CLK_EN_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire psrr_pkg::psrr_addr_t PADDR_IN,
    input wire psrr_pkg::psrr_word_t PWDATA_IN,
    input wire psrr_pkg::psrr_strb_t PSTRB_IN,
    output psrr_pkg::psrr_word_t PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    output logic HARDWARE_DIVIDE_UNIT_OUT,
    output logic IO_PORT_SECOND_RESET_OUT,
    output logic IO_PORT_FIRST_RESET_OUT,
    output logic DMA_RESET_OUT,
    output logic SYSTEM_CONFIG_RESET_OUT,
    output logic DEBUG_BLOCK_RESET_OUT,
    output logic POWER_INTERFACE_RESET_OUT,
    output logic OPAMP_SECOND_RESET_OUT,
    output logic OPAMP_FIRST_RESET_OUT,
    output logic COMPARATOR_RESET_OUT,
    output logic SERIAL_PORT_RESET_OUT,
    output logic ANALOG_CONVERTER_RESET_OUT,
    output logic TIMER_FOURTEEN_RESET_OUT,
    output logic TIMER_THIRTEEN_RESET_OUT,
    output logic BASIC_TIMER_SIX_RESET_OUT,
    output logic TIMER_TWO_RESET_OUT,
    output logic ADVANCED_TIMER_ONE_RESET_OUT
);
    import psrr_pkg::*;

    localparam psrr_addr_t HS_OFFSET = `PSRR_HS_RST_OFFSET;
    localparam psrr_addr_t LS_OFFSET = `PSRR_LS_RST_OFFSET;

    psrr_sel_e sel;
    logic setup_phase;
    logic access_done;
    logic hs_wr_en;
    logic ls_wr_en;
    psrr_word_t hs_rst_q;
    psrr_word_t ls_rst_q;
    psrr_word_t read_d;
    psrr_word_t prdata_q;
    logic pready_q;
    logic pslverr_q;

    // Word decode; the two low address bits are ignored
    always_comb begin
        if (PADDR_IN[7:2] == HS_OFFSET[7:2]) begin
            sel = PSRR_SEL_HS;
        end else if (PADDR_IN[7:2] == LS_OFFSET[7:2]) begin
            sel = PSRR_SEL_LS;
        end else begin
            sel = PSRR_SEL_NONE;
        end
    end

    assign setup_phase = PSEL_IN && !PENABLE_IN;
    assign access_done = PSEL_IN && PENABLE_IN && pready_q;

    // Writes land only at the completing access edge, lane by lane
    assign hs_wr_en = access_done && PWRITE_IN && (sel == PSRR_SEL_HS);
    assign ls_wr_en = access_done && PWRITE_IN && (sel == PSRR_SEL_LS);

    psrr_word #(
        .WRITE_MASK(`PSRR_HS_RST_MASK),
        .RESET_VALUE(`PSRR_HS_RST_RESET)
    ) u_hs_word (
        .clk_in(CLK_IN),
        .reset_n_in(RESET_N_IN),
        .ce_in(CLK_EN_IN),
        .wr_en_in(hs_wr_en),
        .strb_in(PSTRB_IN),
        .wdata_in(PWDATA_IN),
        .q_out(hs_rst_q)
    );

    psrr_word #(
        .WRITE_MASK(`PSRR_LS_RST_MASK),
        .RESET_VALUE(`PSRR_LS_RST_RESET)
    ) u_ls_word (
        .clk_in(CLK_IN),
        .reset_n_in(RESET_N_IN),
        .ce_in(CLK_EN_IN),
        .wr_en_in(ls_wr_en),
        .strb_in(PSTRB_IN),
        .wdata_in(PWDATA_IN),
        .q_out(ls_rst_q)
    );

    // Read mux returns the stored bits; reserved bits are zero in storage
    always_comb begin
        case (sel)
            PSRR_SEL_HS: read_d = hs_rst_q;
            PSRR_SEL_LS: read_d = ls_rst_q;
            default: read_d = `PSRR_READ_IDLE;
        endcase
    end

    // Answer is prepared in the setup cycle if CLK_EN_IN is high then, so the access phase never waits; otherwise PREADY_OUT never rises
    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            pready_q <= 1'b0;
        end else if (CLK_EN_IN) begin
            pready_q <= setup_phase;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            pslverr_q <= 1'b0;
        end else if (CLK_EN_IN) begin
            pslverr_q <= setup_phase && (sel == PSRR_SEL_NONE);
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RESET_N_IN) begin
            prdata_q <= `PSRR_READ_IDLE;
        end else if (CLK_EN_IN) begin
            if (setup_phase && !PWRITE_IN) begin
                prdata_q <= read_d;
            end else begin
                prdata_q <= `PSRR_READ_IDLE;
            end
        end
    end

    assign PRDATA_OUT = prdata_q;
    assign PREADY_OUT = pready_q;
    assign PSLVERR_OUT = pslverr_q;

    // Reset levels come straight from the stored bits
    assign HARDWARE_DIVIDE_UNIT_OUT = hs_rst_q[`PSRR_HS_DIVIDER_BIT];
    assign IO_PORT_SECOND_RESET_OUT = hs_rst_q[`PSRR_HS_PORT_SECOND_BIT];
    assign IO_PORT_FIRST_RESET_OUT = hs_rst_q[`PSRR_HS_PORT_FIRST_BIT];
    assign DMA_RESET_OUT = hs_rst_q[`PSRR_HS_DMA_BIT];
    assign SYSTEM_CONFIG_RESET_OUT = ls_rst_q[`PSRR_LS_SYSTEM_CONFIG_RESET_BIT];
    assign DEBUG_BLOCK_RESET_OUT = ls_rst_q[`PSRR_LS_DEBUG_BIT];
    assign POWER_INTERFACE_RESET_OUT = ls_rst_q[`PSRR_LS_POWER_BIT];
    assign OPAMP_SECOND_RESET_OUT = ls_rst_q[`PSRR_LS_OPAMP_SECOND_BIT];
    assign OPAMP_FIRST_RESET_OUT = ls_rst_q[`PSRR_LS_OPAMP_FIRST_BIT];
    assign COMPARATOR_RESET_OUT = ls_rst_q[`PSRR_LS_COMPARATOR_BIT];
    assign SERIAL_PORT_RESET_OUT = ls_rst_q[`PSRR_LS_SERIAL_BIT];
    assign ANALOG_CONVERTER_RESET_OUT = ls_rst_q[`PSRR_LS_ANALOG_BIT];
    assign TIMER_FOURTEEN_RESET_OUT = ls_rst_q[`PSRR_LS_TIMER_FOURTEEN_BIT];
    assign TIMER_THIRTEEN_RESET_OUT = ls_rst_q[`PSRR_LS_TIMER_THIRTEEN_BIT];
    assign BASIC_TIMER_SIX_RESET_OUT = ls_rst_q[`PSRR_LS_TIMER_SIX_BIT];
    assign TIMER_TWO_RESET_OUT = ls_rst_q[`PSRR_LS_TIMER_TWO_BIT];
    assign ADVANCED_TIMER_ONE_RESET_OUT = ls_rst_q[`PSRR_LS_TIMER_ONE_BIT];

endmodule : psrr_regs

// [psrr_regs_checker.sv]
`timescale 1ns/1ps
`include "psrr_consts.svh"
module psrr_regs_checker (
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic CLK_EN_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire psrr_pkg::psrr_addr_t PADDR_IN,
    input wire psrr_pkg::psrr_word_t PWDATA_IN,
    input wire psrr_pkg::psrr_strb_t PSTRB_IN,
    input wire psrr_pkg::psrr_word_t PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic HARDWARE_DIVIDE_UNIT_OUT,
    input wire logic DMA_RESET_OUT,
    input wire logic ADVANCED_TIMER_ONE_RESET_OUT
);
    import psrr_pkg::*;
    default clocking @(posedge CLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);
    logic wr;
    logic rd;
    logic at_hs;
    logic at_ls;
    assign wr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && CLK_EN_IN;
    assign rd = PREADY_OUT && !PWRITE_IN;
    assign at_hs = PADDR_IN[7:2] == 6'h03;
    assign at_ls = PADDR_IN[7:2] == 6'h06;
    sequence s_setup;
        PSEL_IN && !PENABLE_IN && CLK_EN_IN;
    endsequence
    sequence s_hs_wr;
        wr && at_hs;
    endsequence
    a_zero_wait: assert property (s_setup |=> PREADY_OUT) else $error("no ready");
    a_ready_once: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held");
    a_div_set: assert property ((s_hs_wr ##0 (PSTRB_IN[3] && PWDATA_IN[26]))
        |=> HARDWARE_DIVIDE_UNIT_OUT) else $error("divider not set");
    a_div_clear: assert property ((s_hs_wr ##0 (PSTRB_IN[3] && !PWDATA_IN[26]))
        |=> !HARDWARE_DIVIDE_UNIT_OUT) else $error("divider not cleared");
    a_dma_set: assert property ((s_hs_wr ##0 (PSTRB_IN[0] && PWDATA_IN[0]))
        |=> DMA_RESET_OUT) else $error("dma not set");
    a_timer_one: assert property ((wr && at_ls && PSTRB_IN[0] && PWDATA_IN[0])
        |=> ADVANCED_TIMER_ONE_RESET_OUT) else $error("timer one not set");
    a_hold_idle: assert property ((RESET_N_IN && !wr) |=>
        $stable(HARDWARE_DIVIDE_UNIT_OUT) && $stable(DMA_RESET_OUT))
        else $error("output moved without write");
    a_read_hs: assert property ((rd && at_hs) |->
        PRDATA_OUT[26] == HARDWARE_DIVIDE_UNIT_OUT && PRDATA_OUT[0] == DMA_RESET_OUT)
        else $error("read differs from outputs");
    a_resv_zero: assert property ((rd && at_ls) |->
        (PRDATA_OUT & ~`PSRR_LS_RST_MASK) == 32'h0) else $error("reserved bit read one");
endmodule : psrr_regs_checker

bind psrr_regs psrr_regs_checker u_chk (.*);

// [test_psrr_regs.sv]
`timescale 1ns/1ps
`include "psrr_consts.svh"
module test_psrr_regs;
    import psrr_pkg::*;
    logic CLK_IN = 0, RESET_N_IN = 0, CLK_EN_IN = 1, PSEL_IN = 0, PENABLE_IN = 0;
    logic PWRITE_IN = 0, PREADY_OUT, PSLVERR_OUT, err;
    psrr_addr_t PADDR_IN = 8'h00;
    psrr_word_t PWDATA_IN = 32'h0, PRDATA_OUT, rd;
    psrr_strb_t PSTRB_IN = 4'h0;
    wire psrr_word_t hs_v, ls_v;
    int bad_count = 0, cmp_count = 0;
    always #2 CLK_IN = ~CLK_IN;
    // Each reset output lands on its register bit position
    psrr_regs dut (.*, .HARDWARE_DIVIDE_UNIT_OUT(hs_v[26]), .IO_PORT_SECOND_RESET_OUT(hs_v[18]),
        .IO_PORT_FIRST_RESET_OUT(hs_v[17]), .DMA_RESET_OUT(hs_v[0]),
        .SYSTEM_CONFIG_RESET_OUT(ls_v[30]), .DEBUG_BLOCK_RESET_OUT(ls_v[29]),
        .POWER_INTERFACE_RESET_OUT(ls_v[28]), .OPAMP_SECOND_RESET_OUT(ls_v[26]),
        .OPAMP_FIRST_RESET_OUT(ls_v[25]), .COMPARATOR_RESET_OUT(ls_v[23]),
        .SERIAL_PORT_RESET_OUT(ls_v[16]), .ANALOG_CONVERTER_RESET_OUT(ls_v[13]),
        .TIMER_FOURTEEN_RESET_OUT(ls_v[9]), .TIMER_THIRTEEN_RESET_OUT(ls_v[8]),
        .BASIC_TIMER_SIX_RESET_OUT(ls_v[5]), .TIMER_TWO_RESET_OUT(ls_v[1]),
        .ADVANCED_TIMER_ONE_RESET_OUT(ls_v[0]));
    task automatic tally_and_finish;
        $display("compares %0d errors %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input psrr_word_t e, input psrr_word_t g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input psrr_addr_t a, input psrr_word_t d,
        input psrr_strb_t s);
        int n;
        n = 0;
        PSEL_IN <= 1'b1;
        PWRITE_IN <= w;
        PADDR_IN <= a;
        PWDATA_IN <= d;
        PSTRB_IN <= s;
        @(posedge CLK_IN);
        PENABLE_IN <= 1'b1;
        do begin
            @(posedge CLK_IN);
            n++;
        end while (PREADY_OUT !== 1'b1 && n < 50);
        rd = PRDATA_OUT;
        err = PSLVERR_OUT;
        PSEL_IN <= 1'b0;
        PENABLE_IN <= 1'b0;
        if (n >= 50) begin
            bad_count++;
            tally_and_finish();
        end
        @(posedge CLK_IN);
    endtask : apb
    // Reads a register and compares both the data and the reset outputs
    task automatic rchk(input psrr_addr_t a, input psrr_word_t e);
        psrr_word_t v;
        v = (a == 8'h0c) ? (hs_v & `PSRR_HS_RST_MASK) : (ls_v & `PSRR_LS_RST_MASK);
        chk("outputs", e, v);
        apb(1'b0, a, 32'h0, 4'h0);
        chk("read", e, rd);
        chk("slverr", 32'h0, 32'(err));
    endtask : rchk
    initial begin
        repeat (16) @(posedge CLK_IN);
        RESET_N_IN <= 1'b1;
        @(posedge CLK_IN);
        rchk(8'h0c, 32'h0);
        rchk(8'h18, 32'h0);
        for (int i = 0; i < 32; i++) begin
            apb(1'b1, 8'h0c, `PSRR_HS_RST_MASK & (32'h1 << i), 4'hf);
            rchk(8'h0c, `PSRR_HS_RST_MASK & (32'h1 << i));
            apb(1'b1, 8'h18, `PSRR_LS_RST_MASK & (32'h1 << i), 4'hf);
            rchk(8'h18, `PSRR_LS_RST_MASK & (32'h1 << i));
        end
        apb(1'b1, 8'h18, `PSRR_LS_RST_MASK, 4'h4);
        rchk(8'h18, `PSRR_LS_RST_MASK & 32'h00ff_0000);
        apb(1'b1, 8'h0c, `PSRR_HS_RST_MASK, 4'hf);
        apb(1'b1, 8'h0c, 32'h0, 4'h3);
        rchk(8'h0c, `PSRR_HS_RST_MASK & 32'hffff_0000);
        apb(1'b1, 8'h40, 32'h0, 4'hf);
        chk("unmapped slverr", 32'h1, 32'(err));
        rchk(8'h0c, `PSRR_HS_RST_MASK & 32'hffff_0000);
        RESET_N_IN <= 1'b0;
        @(posedge CLK_IN);
        RESET_N_IN <= 1'b1;
        @(posedge CLK_IN);
        rchk(8'h0c, 32'h0);
        rchk(8'h18, 32'h0);
        tally_and_finish();
    end
endmodule : test_psrr_regs
